// ==== rtl/spi_flags_pkg.sv ====
// shared constants, register map and carrier types for the serial buffer flag block
package spi_flags_pkg;

    // data path widths
    localparam int WORD_W    = 16;
    localparam int ENH_DEPTH = 8;
    localparam int CNT_W     = 4;
    localparam int APB_AW    = 12;
    localparam int APB_DW    = 32;
    localparam int IRQ_W     = 4;

    // register byte offsets on the apb bus
    localparam logic [APB_AW-1:0] OFF_STATUS_CONTROL = 12'h000;
    localparam logic [APB_AW-1:0] OFF_BUFFER         = 12'h004;
    localparam logic [APB_AW-1:0] OFF_IRQ_STATUS     = 12'h008;
    localparam logic [APB_AW-1:0] OFF_IRQ_MASK       = 12'h00c;

    // serial_status_control fields
    localparam int BIT_RX_FULL  = 0;
    localparam int BIT_TX_FULL  = 1;
    localparam int BIT_ENHANCED = 2;
    localparam int TX_CNT_LSB   = 8;
    localparam int RX_CNT_LSB   = 12;

    // interrupt status / mask fields
    localparam int IRQ_RX_DONE     = 0;
    localparam int IRQ_TX_STARTED  = 1;
    localparam int IRQ_RX_OVERFLOW = 2;
    localparam int IRQ_TX_REFUSED  = 3;

    // queue occupancy limits per buffer mode
    localparam logic [CNT_W-1:0] LIMIT_STANDARD = 4'h1;
    localparam logic [CNT_W-1:0] LIMIT_ENHANCED = 4'h8;

    // reset values
    localparam logic [IRQ_W-1:0]  IRQ_RESET   = 4'h0;
    localparam logic [APB_DW-1:0] RDATA_RESET = 32'h0000_0000;
    localparam logic [WORD_W-1:0] WORD_RESET  = 16'h0000;

    typedef enum logic {
        MODE_STANDARD = 1'b0,
        MODE_ENHANCED = 1'b1
    } buffer_mode_t;

    // one word on the shift-register side, with its strobe
    typedef struct packed {
        logic              valid;
        logic [WORD_W-1:0] data;
    } serial_word_t;

endpackage

// ==== rtl/word_queue.sv ====
// word queue with a run-time occupancy limit, used for both transmit and receive buffers
`timescale 1ns/1ps
module word_queue
    import spi_flags_pkg::*;
#(
    parameter int DEPTH = ENH_DEPTH
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              flush,
    input  wire logic [CNT_W-1:0]  limit,
    input  wire logic              push,
    input  wire logic [WORD_W-1:0] push_data,
    input  wire logic              pop,
    output logic      [WORD_W-1:0] head,
    output logic      [CNT_W-1:0]  count,
    output logic                   full,
    output logic                   empty
);
    localparam int IW = $clog2(DEPTH);

    logic [WORD_W-1:0] mem_q [DEPTH];
    logic [IW-1:0]     wr_ptr_q;
    logic [IW-1:0]     rd_ptr_q;
    logic [CNT_W-1:0]  count_q;
    logic [CNT_W-1:0]  count_d;
    wire               push_ok;
    wire               pop_ok;

    // limit may drop below count only around a mode change, which flushes
    assign full    = (count_q >= limit);
    assign empty   = (count_q == '0);
    assign push_ok = push & ~full;
    assign pop_ok  = pop & ~empty;
    assign head    = mem_q[rd_ptr_q];
    assign count   = count_q;

    always_comb begin
        count_d = count_q;
        if (push_ok && !pop_ok) begin
            count_d = count_q + 1'b1;
        end else if (pop_ok && !push_ok) begin
            count_d = count_q - 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else if (flush) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else begin
            wr_ptr_q <= push_ok ? wr_ptr_q + 1'b1 : wr_ptr_q;
            rd_ptr_q <= pop_ok ? rd_ptr_q + 1'b1 : rd_ptr_q;
            count_q  <= count_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= WORD_RESET;
            end
        end else if (push_ok) begin
            mem_q[wr_ptr_q] <= push_data;
        end
    end

endmodule

// ==== rtl/spi_buffer_full_flags.sv ====
// apb-mapped transmit/receive buffers of a serial unit with their full flags and interrupt
`timescale 1ns/1ps
module spi_buffer_full_flags
    import spi_flags_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [APB_AW-1:0] paddr,
    input  wire logic [APB_DW-1:0] pwdata,
    output logic      [APB_DW-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire serial_word_t      rx_in,
    input  wire logic              tx_take,
    output serial_word_t           tx_out,
    output logic                   irq
);

    // apb phase decode
    wire setup_phase;
    wire access_phase;
    wire hit_status;
    wire hit_buffer;
    wire hit_irq_status;
    wire hit_irq_mask;
    wire hit_any;

    assign setup_phase    = psel & ~penable;
    assign access_phase   = psel & penable;
    assign hit_status     = (paddr == OFF_STATUS_CONTROL);
    assign hit_buffer     = (paddr == OFF_BUFFER);
    assign hit_irq_status = (paddr == OFF_IRQ_STATUS);
    assign hit_irq_mask   = (paddr == OFF_IRQ_MASK);
    assign hit_any        = hit_status | hit_buffer | hit_irq_status | hit_irq_mask;

    // every access completes in its first access cycle
    assign pready = 1'b1;

    // access strobes, taken on the completing edge only
    wire wr_status;
    wire wr_buffer;
    wire rd_buffer;
    wire wr_irq_status;
    wire wr_irq_mask;

    assign wr_status     = access_phase & pwrite & hit_status;
    assign wr_buffer     = access_phase & pwrite & hit_buffer;
    assign rd_buffer     = access_phase & ~pwrite & hit_buffer;
    assign wr_irq_status = access_phase & pwrite & hit_irq_status;
    assign wr_irq_mask   = access_phase & pwrite & hit_irq_mask;

    // buffer mode control
    buffer_mode_t mode_q;
    buffer_mode_t mode_d;
    wire          mode_change;

    assign mode_d      = wr_status ? buffer_mode_t'(pwdata[BIT_ENHANCED]) : mode_q;
    // switching to standard depth with more than one word inside would leave counts above the new limit
    assign mode_change = wr_status & (mode_d != mode_q);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= MODE_STANDARD;
        end else begin
            mode_q <= mode_d;
        end
    end

    // one slot in standard mode, the whole queue in enhanced mode
    wire [CNT_W-1:0] limit;
    assign limit = (mode_q == MODE_ENHANCED) ? LIMIT_ENHANCED : LIMIT_STANDARD;

    // transmit side
    wire [WORD_W-1:0] tx_head;
    wire [CNT_W-1:0]  tx_count;
    wire              tx_buffer_full;
    wire              tx_empty;
    wire              tx_push;
    wire              tx_pop;

    // core write of the shared buffer address loads the next free slot
    assign tx_push = wr_buffer;
    // the shift register takes the oldest word and frees its slot
    assign tx_pop  = tx_take & ~tx_empty;

    // full compares the occupancy to the mode limit, so it rises only on the
    // last free slot and falls as soon as one slot is free again
    word_queue #(
        .DEPTH (ENH_DEPTH)
    ) u_tx_queue (
        .pclk      (pclk),
        .presetn   (presetn),
        .flush     (mode_change),
        .limit     (limit),
        .push      (tx_push),
        .push_data (pwdata[WORD_W-1:0]),
        .pop       (tx_pop),
        .head      (tx_head),
        .count     (tx_count),
        .full      (tx_buffer_full),
        .empty     (tx_empty)
    );

    assign tx_out = '{valid: ~tx_empty, data: tx_head};

    // receive side
    wire [WORD_W-1:0] rx_head;
    wire [CNT_W-1:0]  rx_count;
    wire              rx_buffer_full;
    wire              rx_empty;
    wire              rx_push;
    wire              rx_pop;

    // a completed word from the shift register lands in the next free slot
    assign rx_push = rx_in.valid;
    // the core reading the shared buffer address frees the oldest slot
    assign rx_pop  = rd_buffer;

    word_queue #(
        .DEPTH (ENH_DEPTH)
    ) u_rx_queue (
        .pclk      (pclk),
        .presetn   (presetn),
        .flush     (mode_change),
        .limit     (limit),
        .push      (rx_push),
        .push_data (rx_in.data),
        .pop       (rx_pop),
        .head      (rx_head),
        .count     (rx_count),
        .full      (rx_buffer_full),
        .empty     (rx_empty)
    );

    // events; a refused word is dropped, the core is expected to poll first
    wire [IRQ_W-1:0] irq_events;

    assign irq_events[IRQ_RX_DONE]     = rx_in.valid & ~rx_buffer_full;
    assign irq_events[IRQ_TX_STARTED]  = tx_pop;
    assign irq_events[IRQ_RX_OVERFLOW] = rx_in.valid & rx_buffer_full;
    assign irq_events[IRQ_TX_REFUSED]  = wr_buffer & tx_buffer_full;

    // sticky status, write one to clear, a same-cycle event wins
    logic [IRQ_W-1:0] irq_status_q;
    logic [IRQ_W-1:0] irq_mask_q;
    wire  [IRQ_W-1:0] irq_clear;
    wire  [IRQ_W-1:0] irq_status_d;
    wire  [IRQ_W-1:0] irq_mask_d;

    assign irq_clear    = wr_irq_status ? pwdata[IRQ_W-1:0] : '0;
    assign irq_status_d = (irq_status_q & ~irq_clear) | irq_events;
    assign irq_mask_d   = wr_irq_mask ? pwdata[IRQ_W-1:0] : irq_mask_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_q <= IRQ_RESET;
            irq_mask_q   <= IRQ_RESET;
        end else begin
            irq_status_q <= irq_status_d;
            irq_mask_q   <= irq_mask_d;
        end
    end

    assign irq = |(irq_status_q & irq_mask_q);

    // status word; the two full flags come straight from the queues and ignore writes
    logic [APB_DW-1:0] status_word;

    always_comb begin
        status_word                              = '0;
        status_word[BIT_RX_FULL]                 = rx_buffer_full;
        status_word[BIT_TX_FULL]                 = tx_buffer_full;
        status_word[BIT_ENHANCED]                = mode_q;
        status_word[TX_CNT_LSB +: CNT_W]         = tx_count;
        status_word[RX_CNT_LSB +: CNT_W]         = rx_count;
    end

    // read multiplexer
    logic [APB_DW-1:0] read_word;

    always_comb begin
        read_word = '0;
        if (hit_status) begin
            read_word = status_word;
        end else if (hit_buffer) begin
            read_word[WORD_W-1:0] = rx_head;
        end else if (hit_irq_status) begin
            read_word[IRQ_W-1:0] = irq_status_q;
        end else if (hit_irq_mask) begin
            read_word[IRQ_W-1:0] = irq_mask_q;
        end
    end

    // read data and error are sampled in the setup cycle so prdata is a flop;
    // status seen is therefore one cycle older than the completing edge
    logic [APB_DW-1:0] prdata_q;
    logic              miss_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= RDATA_RESET;
            miss_q   <= 1'b0;
        end else if (setup_phase) begin
            prdata_q <= pwrite ? RDATA_RESET : read_word;
            miss_q   <= ~hit_any;
        end
    end

    assign prdata  = prdata_q;
    assign pslverr = access_phase & miss_q;

endmodule

// ==== testbench/spi_buffer_full_flags_props.sv ====
// port-level properties of the serial buffer flag block
`timescale 1ns/1ps
module spi_buffer_full_flags_props
    import spi_flags_pkg::*;
(
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [APB_DW-1:0] pwdata,
    input wire logic [APB_DW-1:0] prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire serial_word_t      rx_in,
    input wire logic              tx_take,
    input wire serial_word_t      tx_out,
    input wire logic              irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic mode_q;
    wire  acc    = psel && penable;
    wire  st_rd  = psel && !penable && !pwrite && paddr == OFF_STATUS_CONTROL;
    wire  st_wr  = acc && pwrite && paddr == OFF_STATUS_CONTROL;
    wire  bf_wr  = acc && pwrite && paddr == OFF_BUFFER;
    wire  mapped = paddr[APB_AW-1:4] == 8'h00 && paddr[1:0] == 2'h0;
    // mode mirror, so standard-mode relations can be told apart
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) mode_q <= 1'b0;
        else if (st_wr) mode_q <= pwdata[BIT_ENHANCED];
    a_reset_quiet: assert property (
        $rose(presetn) |-> prdata == RDATA_RESET && !irq && !tx_out.valid)
        else $error("outputs not quiet after reset");
    a_tx_full_std: assert property (
        st_rd && !mode_q |=> prdata[BIT_TX_FULL] == $past(tx_out.valid))
        else $error("tx full flag disagrees with pending word");
    a_tx_full_cnt: assert property (
        st_rd |=> prdata[BIT_TX_FULL] == (prdata[TX_CNT_LSB+:CNT_W] >=
        (prdata[BIT_ENHANCED] ? LIMIT_ENHANCED : LIMIT_STANDARD)))
        else $error("tx full flag disagrees with tx count");
    a_rx_full_cnt: assert property (
        st_rd |=> prdata[BIT_RX_FULL] == (prdata[RX_CNT_LSB+:CNT_W] >=
        (prdata[BIT_ENHANCED] ? LIMIT_ENHANCED : LIMIT_STANDARD)))
        else $error("rx full flag disagrees with rx count");
    a_status_zero: assert property (
        st_rd |=> prdata[31:16] == 16'h0000 && prdata[7:3] == 5'h00)
        else $error("unused status bits not zero");
    a_tx_push: assert property (
        bf_wr && !tx_take |=> tx_out.valid)
        else $error("buffer write left no pending word");
    a_tx_take_std: assert property (
        tx_take && !mode_q && !bf_wr |=> !tx_out.valid)
        else $error("standard take left word pending");
    a_tx_hold: assert property (
        tx_out.valid && !tx_take && !st_wr |=> tx_out.valid && $stable(tx_out.data))
        else $error("pending word changed before take");
    a_unmapped_err: assert property (
        acc |-> pslverr == !mapped)
        else $error("slave error mismatch on address decode");
    c_enh_full: cover property (st_rd ##1 prdata[BIT_TX_FULL] && prdata[BIT_ENHANCED]);
    c_rx_full: cover property (st_rd ##1 prdata[BIT_RX_FULL] && prdata[BIT_ENHANCED]);
    c_err: cover property (acc && pslverr);
endmodule

bind spi_buffer_full_flags spi_buffer_full_flags_props spi_buffer_full_flags_props_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rx_in, .tx_take, .tx_out, .irq);

// ==== testbench/apb_core_model.sv ====
// processor core model issuing apb transfers to the block's registers
`timescale 1ns/1ps
module apb_core_model
    import spi_flags_pkg::*;
(
    input  wire logic              pclk,
    output logic                   psel,
    output logic                   penable,
    output logic                   pwrite,
    output logic      [APB_AW-1:0] paddr,
    output logic      [APB_DW-1:0] pwdata,
    input  wire logic [APB_DW-1:0] prdata,
    input  wire logic              pready,
    input  wire logic              pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
    end
    // no flag check here: scenarios read status first, and skip it on purpose
    task automatic xfer(input logic w, input logic [APB_AW-1:0] a,
                        input logic [APB_DW-1:0] d, output logic [APB_DW-1:0] r,
                        output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released bus shows garbage, not the last request
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule

// ==== testbench/spi_buffer_full_flags_tb.sv ====
// self-checking bench for the serial buffer flag block
`timescale 1ns/1ps
module spi_buffer_full_flags_tb
    import spi_flags_pkg::*;
;
    logic              pclk = 1'b0;
    logic              presetn = 1'b0;
    logic              tx_take = 1'b0;
    logic              psel, penable, pwrite, pready, pslverr, irq, err;
    logic [APB_AW-1:0] paddr;
    logic [APB_DW-1:0] pwdata, prdata, rd;
    serial_word_t      rx_in = '0;
    serial_word_t      tx_out;
    int                fails = 0, checks = 0, cyc = 0;
    always #2.5 pclk = ~pclk;
    spi_buffer_full_flags spi_buffer_full_flags_i (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rx_in, .tx_take, .tx_out, .irq);
    apb_core_model apb_core_model_i (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr);
    task automatic chk(input string n, input logic [APB_DW-1:0] e, g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [APB_AW-1:0] a, input logic [APB_DW-1:0] d);
        apb_core_model_i.xfer(1'b1, a, d, rd, err);
    endtask
    task automatic rdc(input string n, input logic [APB_AW-1:0] a, input logic [APB_DW-1:0] e);
        apb_core_model_i.xfer(1'b0, a, '0, rd, err);
        chk(n, e, rd);
    endtask
    // irq is sampled mid-cycle so the completing edge has landed
    task automatic irqc(input logic e);
        @(negedge pclk);
        chk("irq", {31'h0, e}, {31'h0, irq});
    endtask
    task automatic rx(input logic [WORD_W-1:0] d);
        @(posedge pclk);
        rx_in <= '{valid: 1'b1, data: d};
        @(posedge pclk);
        rx_in <= '{valid: 1'b0, data: ~d};
    endtask
    task automatic take;
        @(posedge pclk);
        tx_take <= 1'b1;
        @(posedge pclk);
        tx_take <= 1'b0;
    endtask
    task automatic t_std_tx;
        wr(OFF_IRQ_MASK, 32'h8);
        rdc("status", OFF_STATUS_CONTROL, 32'h0);
        irqc(1'b0);
        wr(OFF_BUFFER, 32'ha5c3);
        rdc("status", OFF_STATUS_CONTROL, 32'h0102);
        chk("tx_data", 32'ha5c3, {16'h0, tx_out.data});
        wr(OFF_BUFFER, 32'h1111);
        rdc("status", OFF_STATUS_CONTROL, 32'h0102);
        irqc(1'b1);
        wr(OFF_IRQ_STATUS, 32'h8);
        irqc(1'b0);
        take;
        rdc("status", OFF_STATUS_CONTROL, 32'h0);
        rdc("irq_status", OFF_IRQ_STATUS, 32'h2);
        $display("test std_tx done");
    endtask
    task automatic t_std_rx;
        rx(16'h5a3c);
        rdc("status", OFF_STATUS_CONTROL, 32'h1001);
        rdc("buffer", OFF_BUFFER, 32'h5a3c);
        rdc("status", OFF_STATUS_CONTROL, 32'h0);
        $display("test std_rx done");
    endtask
    task automatic t_enh;
        wr(OFF_STATUS_CONTROL, 32'h4);
        for (int i = 0; i < 8; i++) begin
            rdc("status", OFF_STATUS_CONTROL, 32'h4 | (32'(i) << 8));
            wr(OFF_BUFFER, 32'(i));
        end
        rdc("status", OFF_STATUS_CONTROL, 32'h0806);
        take;
        rdc("status", OFF_STATUS_CONTROL, 32'h0704);
        for (int i = 0; i < 8; i++) begin
            rx(16'(i));
            rdc("status", OFF_STATUS_CONTROL,
                32'h0704 | (32'(i + 1) << 12) | 32'(i == 7));
        end
        rx(16'h0009);
        rdc("status", OFF_STATUS_CONTROL, 32'h8705);
        rdc("irq_status", OFF_IRQ_STATUS, 32'h7);
        rdc("buffer", OFF_BUFFER, 32'h0);
        rdc("status", OFF_STATUS_CONTROL, 32'h7704);
        $display("test enhanced done");
    endtask
    task automatic t_ro;
        wr(OFF_STATUS_CONTROL, 32'h3);
        rdc("status", OFF_STATUS_CONTROL, 32'h0);
        wr(OFF_BUFFER, 32'h0077);
        wr(OFF_STATUS_CONTROL, 32'h0);
        rdc("status", OFF_STATUS_CONTROL, 32'h0102);
        rdc("unmapped", 12'h010, 32'h0);
        chk("slave_error", 32'h1, {31'h0, err});
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdc("status", OFF_STATUS_CONTROL, 32'h0);
        chk("tx_valid", 32'h0, {31'h0, tx_out.valid});
        $display("test read_only done");
    endtask
    task automatic complete_run;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            complete_run;
        end
    end
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_std_tx;
        t_std_rx;
        t_enh;
        t_ro;
        complete_run;
    end
endmodule
